/* File: logic/ocp_defs.vh */
// What this block does
// - After power-up the master configuration clock runs at the 2.08 MHz default.
// - The master clock moves to the chosen frequency once the clock bits arrive.
// - A configuration with no explicit clock choice keeps the 2.08 MHz default.
// - Twenty-one nominal master clock frequencies are offered, 2.08 up to 133 MHz.
// - The oscillator runs only while its programming bit and the user enable both allow it.
// - The oscillator output goes to the clock tree or the PLL reference, optionally divided.
// - The oscillator can be switched off statically and stops in standby.
// - The PLL can be disabled statically and powers down in standby.
// - PLL power is removed only after all PLL output clocks have been driven low.
// - Each primary clock net has its own run-time clock enable.
// - Referenced and differential buffers can be switched off one bank at a time.
// - Power guard can switch off any single input buffer, also clock inputs in standby.
// - Bandgap off in standby also stops monitor, PLL, oscillator and ref/diff buffers.
// - The supply-monitor reset may be disabled in standby; a limited detector stays on.
`ifndef OCP_DEFS_VH
`define OCP_DEFS_VH

// ***********************************************
// register byte offsets
// ***********************************************
`define OCP_REG_CTRL     4'h0
`define OCP_REG_CLKEN    4'h4
`define OCP_REG_BANKOFF  4'h8
`define OCP_REG_GUARD    4'hc
`define OCP_REG_GSTBY    5'h10
`define OCP_REG_STATUS   5'h14

// ***********************************************
// control fields
// ***********************************************
`define OCP_CTRL_OSC_EN   0
`define OCP_CTRL_PLL_EN   1
`define OCP_CTRL_BG_OFF   2
`define OCP_CTRL_POR_OFF  3
`define OCP_CTRL_TO_PLL   4
`define OCP_CTRL_DIV_LO   8
`define OCP_CTRL_DIV_HI   15
`define OCP_CTRL_RST      32'h0000_0103

// ***********************************************
// status fields
// ***********************************************
`define OCP_ST_SEL_HI     4
`define OCP_ST_CFG_DONE   8
`define OCP_ST_STBY       9
`define OCP_ST_OSC_RUN    10
`define OCP_ST_PLL_PWR    11
`define OCP_ST_PLL_HALT   12
`define OCP_ST_BG_ON      13
`define OCP_ST_POR_ON     14
`define OCP_ST_LPD_ON     15

// ***********************************************
// master clock selection
// ***********************************************
`define OCP_MCLK_NUM      5'd21
`define OCP_MCLK_DEF      5'd0
// aclk cycles per master clock period at 250 MHz, entry 20 in the top byte
`define OCP_MDIV_TAB {8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd7, 8'd8, 8'd8, 8'd9, 8'd12, \
  8'd17, 8'd19, 8'd24, 8'd27, 8'd30, 8'd36, 8'd45, 8'd58, 8'd79, 8'd102, 8'd120}

// ***********************************************
// axi responses
// ***********************************************
`define OCP_RESP_OKAY    2'h0
`define OCP_RESP_SLVERR  2'h2

`endif

/* File: logic/ocp_div.v */
`timescale 1ns/1ps
// ***********************************************
// tick divider: one tick every limit steps
// ***********************************************
module ocp_div #(
  parameter W = 8
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         run,
  input  wire         step,
  input  wire [W-1:0] limit,
  output reg          tick_q
);
  reg [W-1:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q  <= {W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (step) begin
        if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= limit) begin
          cnt_q  <= {W{1'b0}};
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: logic/ocp_sync.v */
`timescale 1ns/1ps
// ***********************************************
// three-stage input synchroniser
// ***********************************************
module ocp_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // change is accepted once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule

/* File: logic/ocp_top.v */
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "ocp_defs.vh"
// ***********************************************
// oscillator, clock and power-saving control
// ***********************************************
module ocp_top #(
  parameter NPRI       = 8,
  parameter NBANK      = 4,
  parameter NGUARD     = 16,
  parameter LOW_VOLT   = 1
) (
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite slave
  input  wire [31:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [31:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // configuration loader
  input  wire              cfg_clk_valid,
  input  wire              cfg_clk_explicit,
  input  wire [4:0]        cfg_clk_sel,
  // user fabric
  input  wire              usr_osc_en,
  input  wire              usr_stby_req,
  input  wire              usr_wake_req,
  // pll side, asynchronous
  input  wire              pll_outs_low,
  // controls out
  output reg  [4:0]        mclk_sel_q,
  output wire              mclk_tick,
  output reg               osc_run_q,
  output reg               osc_tree_tick_q,
  output reg               osc_pll_tick_q,
  output reg               pll_pwr_q,
  output reg               pll_halt_q,
  output reg  [NPRI-1:0]   clk_net_en_q,
  output reg  [NBANK-1:0]  bank_off_q,
  output reg  [NGUARD-1:0] ibuf_off_q,
  output reg               bandgap_on_q,
  output reg               por_on_q,
  output reg               lpd_on_q,
  output reg               standby_q
);

  // ***********************************************
  // standby states
  // ***********************************************
  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_DRAIN = 2'b01;
  localparam [1:0] ST_STBY  = 2'b10;
  reg  [1:0]        state_q;
  reg  [31:0]       ctrl_q;
  reg  [NPRI-1:0]   clken_q;
  reg  [NBANK-1:0]  bankreg_q;
  reg  [NGUARD-1:0] guard_q;
  reg  [NGUARD-1:0] gstby_q;
  reg               cfg_done_q;
  wire              pll_low_s;
  wire              osc_tick;
  wire              div_tick;
  wire [167:0]      mdiv_tab = `OCP_MDIV_TAB;
  wire [7:0]        mdiv_lim;
  wire              in_stby;
  wire              bg_cut;
  wire              osc_want;
  wire              pll_want;
  assign in_stby  = (state_q == ST_STBY);
  assign bg_cut   = (LOW_VOLT != 0) && in_stby && ctrl_q[`OCP_CTRL_BG_OFF];
  assign osc_want = ctrl_q[`OCP_CTRL_OSC_EN] && usr_osc_en && !in_stby;
  assign pll_want = ctrl_q[`OCP_CTRL_PLL_EN] && (state_q == ST_RUN);
  assign mdiv_lim = mdiv_tab[{3'b000, mclk_sel_q} * 8 +: 8];
  assign mclk_tick = osc_tick;
  // ***********************************************
  // helpers
  // ***********************************************
  // chain runs only while halted, so a stale low report is never used
  ocp_sync u_pll_low (
    .aclk    (aclk),
    .aresetn (aresetn && pll_halt_q),
    .din     (pll_outs_low),
    .dout_q  (pll_low_s)
  );
  // oscillator at the selected master clock rate
  ocp_div #(.W(8)) u_mclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (osc_run_q),
    .step    (1'b1),
    .limit   (mdiv_lim),
    .tick_q  (osc_tick)
  );
  // user post-divider on the oscillator output
  ocp_div #(.W(8)) u_post (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (osc_run_q),
    .step    (osc_tick),
    .limit   (ctrl_q[`OCP_CTRL_DIV_HI:`OCP_CTRL_DIV_LO]),
    .tick_q  (div_tick)
  );
  // ***********************************************
  // master clock selection
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      mclk_sel_q <= `OCP_MCLK_DEF;
      cfg_done_q <= 1'b0;
    end else if (cfg_clk_valid) begin
      cfg_done_q <= 1'b1;
      if (cfg_clk_explicit && (cfg_clk_sel < `OCP_MCLK_NUM)) begin
        mclk_sel_q <= cfg_clk_sel;
      end else begin
        mclk_sel_q <= `OCP_MCLK_DEF;
      end
    end
  end
  // ***********************************************
  // oscillator run and routing
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_run_q       <= 1'b0;
      osc_tree_tick_q <= 1'b0;
      osc_pll_tick_q  <= 1'b0;
    end else begin
      osc_run_q       <= osc_want && !bg_cut;
      osc_tree_tick_q <= div_tick && !ctrl_q[`OCP_CTRL_TO_PLL];
      osc_pll_tick_q  <= div_tick && ctrl_q[`OCP_CTRL_TO_PLL];
    end
  end
  // ***********************************************
  // pll power with output drain
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pll_pwr_q  <= 1'b0;
      pll_halt_q <= 1'b0;
    end else if (pll_want && !bg_cut) begin
      pll_pwr_q  <= 1'b1;
      pll_halt_q <= 1'b0;
    end else if (pll_pwr_q) begin
      pll_halt_q <= 1'b1;
      if (pll_halt_q && pll_low_s) begin
        pll_pwr_q <= 1'b0;
      end
    end else begin
      pll_halt_q <= 1'b0;
    end
  end
  // ***********************************************
  // standby sequencing
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (usr_stby_req) begin
            state_q <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (usr_wake_req) begin
            state_q <= ST_RUN;
          end else if (!pll_pwr_q) begin
            state_q <= ST_STBY;
          end
        end
        ST_STBY: begin
          if (usr_wake_req) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end
  // ***********************************************
  // power outputs
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      standby_q    <= 1'b0;
      bandgap_on_q <= 1'b1;
      por_on_q     <= 1'b1;
      lpd_on_q     <= 1'b1;
      clk_net_en_q <= {NPRI{1'b1}};
    end else begin
      standby_q    <= in_stby;
      bandgap_on_q <= !bg_cut;
      por_on_q     <= !bg_cut && !(in_stby && ctrl_q[`OCP_CTRL_POR_OFF]);
      lpd_on_q     <= 1'b1;
      clk_net_en_q <= clken_q;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi = gi + 1) begin : g_bank
      always @(posedge aclk) begin
        if (!aresetn) begin
          bank_off_q[gi] <= 1'b0;
        end else begin
          bank_off_q[gi] <= bankreg_q[gi] || bg_cut;
        end
      end
    end
    for (gi = 0; gi < NGUARD; gi = gi + 1) begin : g_guard
      always @(posedge aclk) begin
        if (!aresetn) begin
          ibuf_off_q[gi] <= 1'b0;
        end else begin
          ibuf_off_q[gi] <= guard_q[gi] || (in_stby && gstby_q[gi]);
        end
      end
    end
  endgenerate
  // ***********************************************
  // axi4-lite write channel
  // ***********************************************
  reg  [4:0]  awaddr_q;
  reg         aw_hold_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_hold_q;
  wire [31:0] wmask;
  wire        wr_go;
  wire        wr_hit;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_hit = (awaddr_q == {1'b0, `OCP_REG_CTRL}) || (awaddr_q == {1'b0, `OCP_REG_CLKEN})
               || (awaddr_q == {1'b0, `OCP_REG_BANKOFF}) || (awaddr_q == {1'b0, `OCP_REG_GUARD})
               || (awaddr_q == `OCP_REG_GSTBY);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OCP_RESP_OKAY;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_q     <= 1'b1;
        awaddr_q      <= (s_axi_awaddr[31:5] == 27'h0) ? s_axi_awaddr[4:0] : 5'h1f;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `OCP_RESP_OKAY : `OCP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // ***********************************************
  // control registers
  // ***********************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= `OCP_CTRL_RST;
      clken_q   <= {NPRI{1'b1}};
      bankreg_q <= {NBANK{1'b0}};
      guard_q   <= {NGUARD{1'b0}};
      gstby_q   <= {NGUARD{1'b0}};
    end else if (wr_go) begin
      case (awaddr_q)
        {1'b0, `OCP_REG_CTRL}: begin
          ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_ff1f;
        end
        {1'b0, `OCP_REG_CLKEN}: begin
          clken_q <= (clken_q & ~wmask[NPRI-1:0]) | (wdata_q[NPRI-1:0] & wmask[NPRI-1:0]);
        end
        {1'b0, `OCP_REG_BANKOFF}: begin
          bankreg_q <= (bankreg_q & ~wmask[NBANK-1:0]) | (wdata_q[NBANK-1:0] & wmask[NBANK-1:0]);
        end
        {1'b0, `OCP_REG_GUARD}: begin
          guard_q <= (guard_q & ~wmask[NGUARD-1:0]) | (wdata_q[NGUARD-1:0] & wmask[NGUARD-1:0]);
        end
        `OCP_REG_GSTBY: begin
          gstby_q <= (gstby_q & ~wmask[NGUARD-1:0]) | (wdata_q[NGUARD-1:0] & wmask[NGUARD-1:0]);
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
  // ***********************************************
  // axi4-lite read channel
  // ***********************************************
  reg  [31:0] rd_d;
  reg  [1:0]  rresp_d;
  wire [31:0] status;
  assign status = {16'h0000, lpd_on_q, por_on_q, bandgap_on_q, pll_halt_q, pll_pwr_q,
                   osc_run_q, standby_q, cfg_done_q, 3'b000, mclk_sel_q};
  always @* begin
    rd_d    = 32'h0000_0000;
    rresp_d = `OCP_RESP_OKAY;
    if (s_axi_araddr[31:5] != 27'h0) begin
      rresp_d = `OCP_RESP_SLVERR;
    end else begin
      case (s_axi_araddr[4:0])
        {1'b0, `OCP_REG_CTRL}:    rd_d = ctrl_q;
        {1'b0, `OCP_REG_CLKEN}:   rd_d[NPRI-1:0] = clken_q;
        {1'b0, `OCP_REG_BANKOFF}: rd_d[NBANK-1:0] = bankreg_q;
        {1'b0, `OCP_REG_GUARD}:   rd_d[NGUARD-1:0] = guard_q;
        `OCP_REG_GSTBY:           rd_d[NGUARD-1:0] = gstby_q;
        `OCP_REG_STATUS:          rd_d = status;
        default:                  rresp_d = `OCP_RESP_SLVERR;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OCP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_d;
        s_axi_rresp   <= rresp_d;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* File: sim/ocp_chk.sv */
`timescale 1ns/1ps
`include "ocp_defs.vh"
// ****************************************
// clock and power control checker
// ****************************************
module ocp_chk #(
  parameter NBANK = 4
) (
  input wire             aclk,
  input wire             aresetn,
  input wire             cfg_clk_valid,
  input wire             cfg_clk_explicit,
  input wire [4:0]       cfg_clk_sel,
  input wire             usr_osc_en,
  input wire             usr_stby_req,
  input wire             usr_wake_req,
  input wire             pll_outs_low,
  input wire [4:0]       mclk_sel_q,
  input wire             mclk_tick,
  input wire             osc_run_q,
  input wire             pll_pwr_q,
  input wire             pll_halt_q,
  input wire [NBANK-1:0] bank_off_q,
  input wire             bandgap_on_q,
  input wire             por_on_q,
  input wire             standby_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence stby_ask_s;
    usr_stby_req && !usr_wake_req && !standby_q && !pll_halt_q;
  endsequence

  sequence stby_reached_s;
    standby_q || usr_wake_req;
  endsequence

  osc_gate_a: assert property (!usr_osc_en [*2] |=> !osc_run_q)
    else $error("oscillator runs without user enable");
  osc_rise_a: assert property ($rose(osc_run_q) |-> $past(usr_osc_en))
    else $error("oscillator started without user enable");
  tick_gate_a: assert property (mclk_tick |-> osc_run_q || $past(osc_run_q))
    else $error("clock tick while oscillator stopped");
  cfg_take_a: assert property (cfg_clk_valid && cfg_clk_explicit
    && cfg_clk_sel < `OCP_MCLK_NUM |=> mclk_sel_q == $past(cfg_clk_sel))
    else $error("selected clock not applied");
  cfg_dflt_a: assert property (cfg_clk_valid && !(cfg_clk_explicit
    && cfg_clk_sel < `OCP_MCLK_NUM) |=> mclk_sel_q == `OCP_MCLK_DEF)
    else $error("default clock not applied");
  sel_hold_a: assert property (!cfg_clk_valid |=> $stable(mclk_sel_q))
    else $error("clock selection moved without config");
  pll_off_a: assert property ($fell(pll_pwr_q)
    |-> $past(pll_halt_q) && $past(pll_outs_low, 2))
    else $error("pll power removed before outputs low");
  stby_osc_a: assert property (standby_q && $past(standby_q) |-> !osc_run_q)
    else $error("oscillator runs in standby");
  bg_off_a: assert property (!bandgap_on_q && !$past(bandgap_on_q)
    |-> !pll_pwr_q && !osc_run_q && !por_on_q && &bank_off_q)
    else $error("bandgap off left analog parts on");
  stby_enter_a: assert property (stby_ask_s |-> ##[1:60] stby_reached_s)
    else $error("standby not reached");
endmodule

bind ocp_top ocp_chk #(.NBANK(NBANK)) ocp_chk_inst (
  .aclk, .aresetn, .cfg_clk_valid, .cfg_clk_explicit, .cfg_clk_sel, .usr_osc_en,
  .usr_stby_req, .usr_wake_req, .pll_outs_low, .mclk_sel_q, .mclk_tick, .osc_run_q,
  .pll_pwr_q, .pll_halt_q, .bank_off_q, .bandgap_on_q, .por_on_q, .standby_q
);

/* File: sim/ocp_pll_mdl.sv */
`timescale 1ns/1ps
// ****************************************
// pll stand-in: outputs park low after halt
// ****************************************
module ocp_pll_mdl (
  input  wire aclk,
  input  wire aresetn,
  input  wire halt,
  input  wire pwr,
  input  wire slow,
  output reg  outs_low
);
  reg [3:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn || !halt) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // running outputs until halted long enough, low once unpowered
  always @* begin
    outs_low = !pwr || (halt && cnt_q >= (slow ? 4'h9 : 4'h1));
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "ocp_defs.vh"
// ****************************************
// clock and power control bench
// ****************************************
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        cfg_clk_valid = 1'b0, cfg_clk_explicit = 1'b0;
  logic [4:0]  cfg_clk_sel = 5'h0;
  logic        usr_osc_en = 1'b1, usr_stby_req = 1'b0, usr_wake_req = 1'b0;
  wire         pll_outs_low, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, mclk_tick, osc_run_q, osc_tree_tick_q, osc_pll_tick_q;
  wire         pll_pwr_q, pll_halt_q, bandgap_on_q, por_on_q, lpd_on_q, standby_q;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [4:0]   mclk_sel_q;
  wire [7:0]   clk_net_en_q;
  wire [3:0]   bank_off_q;
  wire [15:0]  ibuf_off_q;
  wire [3:0]   tk = {1'b0, osc_pll_tick_q, osc_tree_tick_q, mclk_tick};
  int          mismatches = 0, comparisons = 0, cyc = 0, n, ex;
  logic [31:0] d, b, g, s, rst_v [7] = '{32'h103, 32'hff, 0, 0, 0, 32'hec00, 0};
  logic [1:0]  r;

  ocp_top ocp_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_clk_valid, .cfg_clk_explicit,
    .cfg_clk_sel, .usr_osc_en, .usr_stby_req, .usr_wake_req, .pll_outs_low, .mclk_sel_q,
    .mclk_tick, .osc_run_q, .osc_tree_tick_q, .osc_pll_tick_q, .pll_pwr_q, .pll_halt_q,
    .clk_net_en_q, .bank_off_q, .ibuf_off_q, .bandgap_on_q, .por_on_q, .lpd_on_q,
    .standby_q);
  ocp_pll_mdl ocp_pll_mdl_inst (.aclk, .aresetn, .halt(pll_halt_q), .pwr(pll_pwr_q),
    .slow, .outs_low(pll_outs_low));

  always #2 aclk = ~aclk;

  function automatic int per(input int i);
    logic [167:0] t;
    t = `OCP_MDIV_TAB;
    return int'(t[i*8 +: 8]);
  endfunction

  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task axw(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task cfg(input logic e, input logic [4:0] sel);
    @(posedge aclk);
    cfg_clk_valid <= 1'b1;
    cfg_clk_explicit <= e;
    cfg_clk_sel <= sel;
    @(posedge aclk);
    cfg_clk_valid <= 1'b0;
  endtask

  task pulse(input logic wake);
    @(posedge aclk);
    usr_stby_req <= !wake;
    usr_wake_req <= wake;
    @(posedge aclk);
    usr_stby_req <= 1'b0;
    usr_wake_req <= 1'b0;
  endtask

  task automatic gap(input int w, output int m);
    m = 0;
    @(posedge aclk iff tk[w]);
    do begin
      @(posedge aclk);
      m++;
      if (tk[3-w]) m += 1000;
    end while (!tk[w]);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      close_out;
    end
  end

  initial begin
    void'($urandom(32'heaa32995));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(mclk_sel_q, 0, "boot sel");
    gap(0, n);
    chk(n, per(0), "boot period");
    for (int i = 0; i < 7; i++) begin
      axr(i * 4);
      chk(d, rst_v[i], "reset value");
      chk(r, (i == 6) ? 2 : 0, "read resp");
    end
    axw(32'h14, 32'h0);
    chk(r, 2, "status write resp");
    for (int i = 0; i < 23; i++) begin
      cfg(i != 7, i[4:0]);
      ex = (i != 7 && i < 21) ? i : 0;
      repeat (2) @(posedge aclk);
      chk(mclk_sel_q, ex, "clock sel");
      gap(0, n);
      chk(n, per(ex), "clock period");
    end
    b = $urandom;
    g = $urandom;
    s = $urandom;
    d = $urandom;
    axw(32'h04, d);
    axw(32'h08, b);
    axw(32'h0c, g);
    s_axi_wstrb <= 4'h2;
    axw(32'h0c, ~g);
    s_axi_wstrb <= 4'hf;
    g[15:8] = ~g[15:8];
    repeat (3) @(posedge aclk);
    chk(clk_net_en_q, d[7:0], "net enables");
    chk(bank_off_q, b[3:0], "bank off");
    chk(ibuf_off_q, g[15:0], "guard off");
    cfg(1'b1, 5'd20);
    for (int k = 0; k < 2; k++) begin
      axw(32'h00, 32'h0303 | (k << 4));
      gap(k + 1, n);
      chk(n, 3 * per(20), "osc route divide");
    end
    for (int c = 0; c < 8; c++) begin
      axw(32'h00, c & 3);
      usr_osc_en <= c[2];
      repeat (16) @(posedge aclk);
      chk(osc_run_q, c[0] & c[2], "osc enable");
      chk(pll_pwr_q, c[1], "pll static enable");
    end
    axw(32'h10, s);
    for (int k = 0; k < 2; k++) begin
      slow <= (k == 0);
      axw(32'h00, k ? 32'h0b : 32'h0f);
      pulse(1'b0);
      repeat (2) @(posedge aclk);
      chk(pll_halt_q, 1, "drain halt");
      chk(pll_pwr_q, 1, "drain pll held");
      @(posedge aclk iff standby_q === 1'b1);
      repeat (3) @(posedge aclk);
      chk(osc_run_q, 0, "standby osc");
      chk(pll_pwr_q, 0, "standby pll");
      chk(bandgap_on_q, k, "standby bandgap");
      chk(por_on_q, 0, "standby por");
      chk(lpd_on_q, 1, "standby detector");
      chk(bank_off_q, k ? b[3:0] : 4'hf, "standby banks");
      chk(ibuf_off_q, g[15:0] | s[15:0], "standby guard");
      axr(32'h14);
      chk(d, 32'h8314 | (k << 13), "standby status");
      pulse(1'b1);
      repeat (16) @(posedge aclk);
      chk(standby_q, 0, "woken");
      chk(osc_run_q, 1, "wake osc");
      chk(pll_pwr_q, 1, "wake pll");
      chk(bandgap_on_q, 1, "wake bandgap");
      chk(ibuf_off_q, g[15:0], "wake guard");
    end
    pulse(1'b0);
    pulse(1'b1);
    repeat (16) @(posedge aclk);
    chk(standby_q, 0, "drain abort");
    chk(pll_pwr_q, 1, "drain abort pll");
    close_out;
  end
endmodule
